// >>> rtl/spe_defs.svh
// spe_defs.svh: field layouts, reset values and counts for the serial peripheral block
// assumes: included by bare name from the package and the design modules
`ifndef SPE_DEFS_SVH
`define SPE_DEFS_SVH
`define SPE_DATA_W 8
`define SPE_NCS 4
`define SPE_BAUD_W 8
`define SPE_BAUD_ONE 8'h01
`define SPE_BIT_LAST 3'h7
`define SPE_CS_NONE 4'hf
`define SPE_WORD_ZERO 8'h00
`define SPE_CNT_ZERO 8'h00
`endif

// >>> rtl/spe_pkg.sv
// spe_pkg.sv: types shared by the serial peripheral block
// assumes: spe_defs.svh is on the include path
`include "spe_defs.svh"
package spe_pkg;
   // transfer engine states, gray coded along idle-low-high-done
   typedef enum logic [1:0] {
      spe_idle = 2'b00,
      spe_low = 2'b01,
      spe_high = 2'b11,
      spe_done = 2'b10
   } spe_state_e;
endpackage : spe_pkg

// >>> rtl/spe_word_reg.sv
// spe_word_reg.sv: one registered data word with load and clear
// assumes: single clock, synchronous active-high reset
`timescale 1ns/1ns
`include "spe_defs.svh"
module spe_word_reg #(
   parameter int WIDTH = `SPE_DATA_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clear,
   input wire logic load,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   // clear wins so a soft reset empties the word
   always_ff @(posedge clk) begin
      if (reset || clear) begin
         dout <= '0;
      end else if (load) begin
         dout <= din;
      end
   end
endmodule : spe_word_reg

// >>> rtl/spe_core.sv
// spe_core.sv: serial peripheral master/slave engine with its silicon quirks kept
// assumes: all inputs synchronous to clk; software controls are plain ports
`timescale 1ns/1ns
`include "spe_defs.svh"
module spe_core #(
   parameter int NCS = `SPE_NCS
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic enable_cmd,
   input wire logic disable_cmd,
   input wire logic soft_reset_bit,
   input wire logic master_mode,
   input wire logic fault_detect_disable,
   input wire logic cs_hold_after_transfer,
   input wire logic clock_polarity,
   input wire logic clock_phase_bit,
   input wire logic [1:0] cs_select,
   input wire logic [NCS*`SPE_BAUD_W-1:0] serial_baud_divider,
   input wire logic tx_write,
   input wire logic [`SPE_DATA_W-1:0] tx_data,
   input wire logic rx_read,
   input wire logic miso,
   input wire logic slave_sck,
   input wire logic slave_cs_n,
   input wire logic mosi_in,
   output logic enabled,
   output logic tx_empty_flag,
   output logic rx_full_flag,
   output logic [`SPE_DATA_W-1:0] rx_word_reg,
   output logic [NCS-1:0] rx_chip_select_field,
   output logic sck,
   output logic mosi,
   output logic [NCS-1:0] chip_select_pins_n,
   output logic miso_out
);
   // the select decode and the divider picker are built for four selects only
   if (NCS != `SPE_NCS) begin : g_bad_ncs
      $error("spe_core serves exactly four chip selects");
   end

   // ----------------------------------------------------------------
   // decoding
   // ----------------------------------------------------------------
   spe_pkg::spe_state_e state;
   logic [`SPE_BAUD_W-1:0] cnt;
   logic [2:0] bitn;
   logic [`SPE_DATA_W-1:0] shreg;
   logic [`SPE_DATA_W-1:0] tx_word_reg;
   logic slave_sck_d;
   logic [NCS-1:0] cs_last;

   function automatic logic [`SPE_BAUD_W-1:0] div_of(input logic [NCS*`SPE_BAUD_W-1:0] v, input logic [1:0] i);
      div_of = v[i*`SPE_BAUD_W +: `SPE_BAUD_W];
   endfunction : div_of

   wire [`SPE_BAUD_W-1:0] div_sel = div_of(serial_baud_divider, cs_select);
   logic [NCS-1:0] div_is_one;
   genvar g;
   generate
      for (g = 0; g < NCS; g++) begin : g_div
         assign div_is_one[g] = (div_of(serial_baud_divider, 2'(g)) == `SPE_BAUD_ONE);
      end
   endgenerate
   // mixed dividers in idle-high, phase-clear mode add a pulse
   wire glitch_mode = (|div_is_one) && !(&div_is_one) && clock_polarity && !clock_phase_bit;
   // disable is only honoured in master mode
   wire do_disable = disable_cmd && master_mode;
   wire tx_accept = tx_write && enabled;
   // hold-after-transfer with fault detect on blocks start, whichever select is chosen
   wire start_block = cs_hold_after_transfer && !fault_detect_disable;
   wire start_go = enabled && master_mode && !tx_empty_flag && !start_block && state == spe_pkg::spe_idle;
   wire half_tick = (cnt == `SPE_CNT_ZERO);
   wire [`SPE_BAUD_W-1:0] reload = (div_sel == `SPE_CNT_ZERO) ? `SPE_CNT_ZERO : div_sel - `SPE_BAUD_ONE;
   wire slave_rise = slave_sck && !slave_sck_d && !slave_cs_n;
   wire slave_fall = !slave_sck && slave_sck_d && !slave_cs_n;
   wire [`SPE_DATA_W-1:0] slave_next = {shreg[`SPE_DATA_W-2:0], mosi_in};
   wire slave_word_end = slave_rise && bitn == `SPE_BIT_LAST;
   wire master_word_end = state == spe_pkg::spe_done;
   logic [NCS-1:0] cs_decode;
   assign cs_decode = ~(4'h1 << cs_select);

   // ----------------------------------------------------------------
   // enable and status
   // ----------------------------------------------------------------
   // soft reset clears control and status, leaves block disabled
   always_ff @(posedge clk) begin
      if (reset || soft_reset_bit) begin
         enabled <= 1'b0;
      end else if (do_disable) begin
         enabled <= 1'b0;
      end else if (enable_cmd) begin
         enabled <= 1'b1;
      end
   end

   // empty flag ignores disable; load and set share a cycle safely
   always_ff @(posedge clk) begin
      if (reset || soft_reset_bit) begin
         tx_empty_flag <= 1'b1;
      end else if (tx_accept) begin
         tx_empty_flag <= 1'b0;
      end else if (start_go) begin
         tx_empty_flag <= 1'b1;
      end
   end

   spe_word_reg #(.WIDTH(`SPE_DATA_W)) u_tx (
      .clk(clk),
      .reset(reset),
      .clear(soft_reset_bit),
      .load(tx_accept),
      .din(tx_data),
      .dout(tx_word_reg)
   );

   // receive flag: a new word beats a read in the same cycle
   always_ff @(posedge clk) begin
      if (reset || soft_reset_bit) begin
         rx_full_flag <= 1'b0;
         rx_word_reg <= `SPE_WORD_ZERO;
         rx_chip_select_field <= `SPE_CS_NONE;
      end else if (master_word_end || (slave_word_end && enabled)) begin
         rx_full_flag <= 1'b1;
         rx_word_reg <= master_word_end ? shreg : slave_next;
         // field shows the select pins as they stood before the last master start, not this word's select
         rx_chip_select_field <= cs_last;
      end else if (rx_read) begin
         rx_full_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // master transfer engine
   // ----------------------------------------------------------------
   // one half period per divider count; extra pulse injected in glitch mode
   always_ff @(posedge clk) begin
      if (reset || soft_reset_bit) begin
         state <= spe_pkg::spe_idle;
         cnt <= `SPE_CNT_ZERO;
         bitn <= 3'h0;
         shreg <= `SPE_WORD_ZERO;
         sck <= 1'b0;
         mosi <= 1'b0;
         chip_select_pins_n <= `SPE_CS_NONE;
         cs_last <= `SPE_CS_NONE;
         slave_sck_d <= 1'b0;
         miso_out <= 1'b0;
      end else begin
         slave_sck_d <= slave_sck;
         case (state)
            spe_pkg::spe_idle: begin
               sck <= clock_polarity;
               if (!cs_hold_after_transfer) chip_select_pins_n <= `SPE_CS_NONE;
               if (start_go) begin
                  state <= spe_pkg::spe_low;
                  shreg <= tx_word_reg;
                  mosi <= tx_word_reg[`SPE_DATA_W-1];
                  chip_select_pins_n <= cs_decode;
                  cs_last <= chip_select_pins_n;
                  cnt <= reload;
                  bitn <= 3'h0;
                  // the stray edge pair appears at word start
                  if (glitch_mode) sck <= !clock_polarity;
               end else if (master_mode == 1'b0 && enabled) begin
                  // slave shifting on the external clock
                  if (slave_rise) begin
                     shreg <= slave_next;
                     bitn <= bitn + 3'h1;
                  end
                  if (slave_fall) miso_out <= shreg[`SPE_DATA_W-1];
                  if (slave_cs_n) bitn <= 3'h0;
               end
            end
            spe_pkg::spe_low: begin
               if (sck != clock_polarity) begin
                  // close the stray pulse first, even with a divider of 1
                  sck <= clock_polarity;
               end else if (half_tick) begin
                  state <= spe_pkg::spe_high;
                  sck <= !clock_polarity;
                  shreg <= {shreg[`SPE_DATA_W-2:0], miso};
                  cnt <= reload;
               end else begin
                  cnt <= cnt - `SPE_BAUD_ONE;
               end
            end
            spe_pkg::spe_high: begin
               if (half_tick) begin
                  sck <= clock_polarity;
                  mosi <= shreg[`SPE_DATA_W-1];
                  cnt <= reload;
                  bitn <= bitn + 3'h1;
                  state <= (bitn == `SPE_BIT_LAST) ? spe_pkg::spe_done : spe_pkg::spe_low;
               end else begin
                  cnt <= cnt - `SPE_BAUD_ONE;
               end
            end
            spe_pkg::spe_done: begin
               state <= spe_pkg::spe_idle;
            end
            default: state <= spe_pkg::spe_idle;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // no start while held select and fault detect on
   hold_block_a: assert property (@(posedge clk) disable iff (reset)
      (start_block && state == spe_pkg::spe_idle) |=> state == spe_pkg::spe_idle)
      else $error("transfer started while blocked");
   // disabled write keeps the empty flag
   empty_keep_a: assert property (@(posedge clk) disable iff (reset || soft_reset_bit)
      (tx_write && !enabled && tx_empty_flag && !start_go) |=> tx_empty_flag)
      else $error("empty flag cleared by filtered write");
   // disable alone does not set empty
   disable_flag_a: assert property (@(posedge clk) disable iff (reset || soft_reset_bit)
      (!enabled && !tx_empty_flag && !start_go) |=> !tx_empty_flag)
      else $error("empty flag moved while disabled");
   slave_stays_a: assert property (@(posedge clk) disable iff (reset)
      (enabled && !master_mode && !soft_reset_bit) |=> enabled)
      else $error("slave was disabled");
   // soft reset leaves idle and disabled
   soft_reset_a: assert property (@(posedge clk) disable iff (reset)
      soft_reset_bit |=> (!enabled && tx_empty_flag && !rx_full_flag && state == spe_pkg::spe_idle))
      else $error("soft reset incomplete");
   // glitch mode pulses the clock at start
   extra_pulse_a: assert property (@(posedge clk) disable iff (reset || soft_reset_bit)
      (start_go && glitch_mode) |=> sck != clock_polarity)
      else $error("no extra pulse");
   stale_cs_a: assert property (@(posedge clk) disable iff (reset || soft_reset_bit)
      master_word_end |=> rx_chip_select_field == $past(cs_last))
      else $error("chip select field mismatch");
endmodule : spe_core

// >>> tb/spe_slave_model.sv
// spe_slave_model.sv: behavioural slave device hanging on chip select 0 of the master
// assumes: sck and cs_n arrive registered in the clk domain; cpol matches the master's setting
`timescale 1ns/1ns
module spe_slave_model (
   input wire logic clk,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic cpol,
   input wire logic [7:0] reply,
   output logic miso,
   output logic [7:0] got
);
   logic [7:0] shreg;
   logic last_sck = 1'b0;
   logic flip = 1'b0;
   // -----------------------------------------------
   // shift engine
   // -----------------------------------------------
   // capture on the leading edge, shift on the trailing one, so miso is steady when the master samples
   always @(posedge clk) begin
      last_sck <= sck;
      flip <= ~flip;
      if (cs_n) begin
         shreg <= reply;
      end else if (sck != last_sck && sck != cpol) begin
         got <= {got[6:0], mosi};
      end else if (sck != last_sck) begin
         shreg <= {shreg[6:0], 1'b0};
      end
   end
   // deselected line wanders so a stale bit can never pass for data;
   // the next bit shows as soon as the trailing edge is seen, so a divider of 1 still meets the sample
   assign miso = cs_n ? flip : ((sck != last_sck && sck == cpol) ? shreg[6] : shreg[7]);
endmodule : spe_slave_model

// >>> tb/tb_spe_core.sv
// tb_spe_core.sv: self-checking bench for the serial peripheral engine, master and slave
// assumes: spe_core with four chip selects; slave model on select 0
`timescale 1ns/1ns
module tb_spe_core;
   logic clk = 0, reset = 1, master_mode = 1, fault_detect_disable = 1, cs_hold_after_transfer = 0;
   logic clock_polarity = 0, clock_phase_bit = 0, tx_write = 0, slave_sck = 0, slave_cs_n = 1, mosi_in = 0;
   logic [3:0] cmd = 4'h0;
   logic [31:0] serial_baud_divider = 32'h02020202;
   logic [7:0] tx_data = 8'h00, reply = 8'h3c, got, rx_word_reg;
   logic [3:0] rx_chip_select_field, chip_select_pins_n;
   logic enabled, tx_empty_flag, rx_full_flag, sck, mosi, miso, miso_out;
   int errors = 0, checks_done = 0;
   wire enable_cmd = cmd[0], disable_cmd = cmd[1], soft_reset_bit = cmd[2], rx_read = cmd[3];
   spe_core u_spe_core (.clk(clk), .reset(reset), .enable_cmd(enable_cmd), .disable_cmd(disable_cmd),
      .soft_reset_bit(soft_reset_bit), .master_mode(master_mode), .fault_detect_disable(fault_detect_disable),
      .cs_hold_after_transfer(cs_hold_after_transfer), .clock_polarity(clock_polarity),
      .clock_phase_bit(clock_phase_bit), .cs_select(2'h0), .serial_baud_divider(serial_baud_divider),
      .tx_write(tx_write), .tx_data(tx_data), .rx_read(rx_read), .miso(miso), .slave_sck(slave_sck),
      .slave_cs_n(slave_cs_n), .mosi_in(mosi_in), .enabled(enabled), .tx_empty_flag(tx_empty_flag),
      .rx_full_flag(rx_full_flag), .rx_word_reg(rx_word_reg), .rx_chip_select_field(rx_chip_select_field),
      .sck(sck), .mosi(mosi), .chip_select_pins_n(chip_select_pins_n), .miso_out(miso_out));
   spe_slave_model u_spe_slave_model (.clk(clk), .cs_n(chip_select_pins_n[0]), .sck(sck), .mosi(mosi),
      .cpol(clock_polarity), .reply(reply), .miso(miso), .got(got));
   initial begin
      forever #5 clk = ~clk;
   end
   // -----------------------------------------------
   // shared tasks
   // -----------------------------------------------
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   // one-cycle command strobe; the edge that samples it has already landed on return
   task automatic pulse(input logic [3:0] m);
      @(posedge clk);
      cmd <= m;
      @(posedge clk);
      cmd <= 4'h0;
      #1;
   endtask : pulse
   task automatic send(input logic [7:0] d);
      @(posedge clk);
      tx_data <= d;
      tx_write <= 1'b1;
      @(posedge clk);
      tx_write <= 1'b0;
   endtask : send
   // counts moves of sck to its active level until the word lands, bounded against a hang
   task automatic wait_rx(input logic [7:0] exp_pulses, input logic [7:0] exp_rx, input bit data_ok);
      int n;
      logic [7:0] p;
      logic last;
      #1;
      last = sck;
      p = 8'h00;
      for (n = 0; n < 400 && rx_full_flag !== 1'b1; n++) begin
         @(posedge clk);
         #1;
         if (sck !== last && sck === ~clock_polarity) p++;
         last = sck;
      end
      if (n == 400) begin
         errors++;
         tally_and_finish();
      end
      chk("sck_pulses", p, exp_pulses);
      if (data_ok) chk("rx_word_reg", rx_word_reg, exp_rx);
      if (data_ok) chk("slave_got", got, tx_data);
      pulse(4'h8);
      chk("rx_full_flag", rx_full_flag, 8'h00);
   endtask : wait_rx
   task automatic slave_byte(input logic [7:0] d);
      int i;
      @(posedge clk);
      slave_cs_n <= 1'b0;
      for (i = 7; i >= 0; i--) begin
         repeat (2) @(posedge clk);
         mosi_in <= d[i];
         slave_sck <= 1'b0;
         repeat (2) @(posedge clk);
         slave_sck <= 1'b1;
      end
      repeat (2) @(posedge clk);
      slave_sck <= 1'b0;
      mosi_in <= ~d[0];
      repeat (3) @(posedge clk);
      slave_cs_n <= 1'b1;
      #1;
   endtask : slave_byte
   // -----------------------------------------------
   // main sequence
   // -----------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      chk("enabled", enabled, 8'h00);
      chk("tx_empty_flag", tx_empty_flag, 8'h01);
      chk("cs_pins", chip_select_pins_n, 8'h0f);
      send(8'h11);
      send(8'h22);
      repeat (20) @(posedge clk);
      #1;
      chk("tx_empty_flag", tx_empty_flag, 8'h01);
      chk("cs_pins", chip_select_pins_n, 8'h0f);
      // enable first, fault detect off, then feed
      pulse(4'h1);
      send(8'ha5);
      wait_rx(8'h08, 8'h3c, 1'b1);
      reply <= 8'hc3;
      send(8'h5a);
      wait_rx(8'h08, 8'hc3, 1'b1);
      fault_detect_disable <= 1'b0;
      cs_hold_after_transfer <= 1'b1;
      send(8'h69);
      repeat (40) @(posedge clk);
      #1;
      chk("tx_empty_flag", tx_empty_flag, 8'h00);
      chk("cs_pins", chip_select_pins_n, 8'h0f);
      // disable with a word pending: flag holds, a late feeder write is lost
      pulse(4'h2);
      chk("tx_empty_flag", tx_empty_flag, 8'h00);
      send(8'h77);
      pulse(4'h1);
      // the slave must still see the word held before the disable
      tx_data <= 8'h69;
      fault_detect_disable <= 1'b1;
      cs_hold_after_transfer <= 1'b0;
      wait_rx(8'h08, 8'hc3, 1'b1);
      clock_polarity <= 1'b1;
      serial_baud_divider <= 32'h04040401;
      repeat (4) @(posedge clk);
      send(8'h96);
      wait_rx(8'h09, 8'h00, 1'b0);
      // every divider at 1 in this clock mode
      serial_baud_divider <= 32'h01010101;
      send(8'h3e);
      wait_rx(8'h08, 8'hc3, 1'b1);
      pulse(4'h2);
      chk("enabled", enabled, 8'h00);
      master_mode <= 1'b0;
      pulse(4'h1);
      pulse(4'h2);
      chk("enabled", enabled, 8'h01);
      slave_byte(8'hc9);
      chk("rx_full_flag", rx_full_flag, 8'h01);
      chk("rx_word_reg", rx_word_reg, 8'hc9);
      // read the last word, then soft reset
      pulse(4'h8);
      pulse(4'h4);
      chk("enabled", enabled, 8'h00);
      chk("tx_empty_flag", tx_empty_flag, 8'h01);
      chk("rx_full_flag", rx_full_flag, 8'h00);
      chk("rx_word_reg", rx_word_reg, 8'h00);
      chk("rx_cs_field", rx_chip_select_field, 8'h0f);
      chk("mosi", mosi, 8'h00);
      chk("miso_out", miso_out, 8'h00);
      tally_and_finish();
   end
endmodule : tb_spe_core
